// *** rtl/sfpm_pkg.sv ***
// Overview of operation
// - serial clock at most half module clock
// - transfer runs alone once started
// - completion sets done flag and interrupt
// - one transfer holds up to eight phases
// - each phase has direction, lanes, count
// - phases run in ascending order, then end
// - chip select low frames whole transfer
// - everything runs on the single module clock
// - register port, dma handshakes, one interrupt
// - start write makes sequencer decode phases
// - bus accesses become register reads/writes
// - register unit owns dma and interrupt
// - programmable divider sets serial clock rate
// - engine drives and samples data lanes
// - each lane has own data, enable
package sfpm_pkg;

    // register port
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    localparam int DATA_WORDS = 16;
    localparam int PHASES = 8;

    // register byte offsets
    localparam logic [REG_AW-1:0] CTRL_OFF = 8'h00;
    localparam logic [REG_AW-1:0] STATUS_OFF = 8'h04;
    localparam logic [REG_AW-1:0] CLEAR_OFF = 8'h08;
    localparam logic [REG_AW-1:0] ENABLE_OFF = 8'h0c;
    localparam logic [REG_AW-1:0] PHASE_BASE = 8'h20;
    localparam logic [REG_AW-1:0] PHASE_MASK = 8'he0;
    localparam logic [REG_AW-1:0] DATA_BASE = 8'h40;
    localparam logic [REG_AW-1:0] DATA_MASK = 8'hc0;
    localparam int DATA_WINDOW_WORDS = 16;

    // control register fields
    localparam int START_BIT = 0;
    localparam int DONE_BIT = 1;
    localparam int DMA_BIT = 2;
    localparam int LAST_LSB = 4;
    localparam int LAST_W = 3;
    localparam int DIV_LSB = 8;
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h01;

    // phase register fields
    localparam int PCFG_W = 16;
    localparam int DIR_BIT = 0;
    localparam int LANES_LSB = 1;
    localparam int CNT_LSB = 4;
    localparam int CNT_W = 12;

    // lane width codes
    localparam logic [1:0] LANES_1 = 2'h0;
    localparam logic [1:0] LANES_2 = 2'h1;

    // interrupt events
    localparam int EV_W = 2;
    localparam int EV_DONE = 0;
    localparam int EV_REJECT = 1;

    // lane levels between transfers: lanes 2 and 3 held high, lane 1 free for input
    localparam logic [3:0] IDLE_OUT = 4'hc;
    localparam logic [3:0] IDLE_DRIVE = 4'hd;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PHASE,
        ST_FETCH,
        ST_LOAD,
        ST_SHIFT,
        ST_STORE,
        ST_END
    } sfpm_state_e;

endpackage : sfpm_pkg

// *** rtl/sfpm_mem_if.sv ***
`timescale 1ns/1ps
// two ports into the data buffer: register side and serial engine side
interface sfpm_mem_if #(parameter int AW = 4);
    logic a_wr;
    logic [AW-1:0] a_addr;
    logic [31:0] a_wdata;
    logic [31:0] a_rdata;
    logic [AW-1:0] b_addr;
    logic [3:0] b_wbe;
    logic [31:0] b_wdata;
    logic [31:0] b_rdata;

    modport ctrl (
        output a_wr, a_addr, a_wdata, b_addr, b_wbe, b_wdata,
        input a_rdata, b_rdata
    );
    modport mem (
        input a_wr, a_addr, a_wdata, b_addr, b_wbe, b_wdata,
        output a_rdata, b_rdata
    );
endinterface : sfpm_mem_if

// *** rtl/sfpm_data_mem.sv ***
`timescale 1ns/1ps
module sfpm_data_mem #(
    parameter int DEPTH = sfpm_pkg::DATA_WORDS,
    parameter int AW = 4
) (
    input wire logic ref_clk_in, // module clock
    input wire logic reset_in, // async reset, active high
    sfpm_mem_if.mem mem_port // both access ports
);
    import sfpm_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][31:0] word;
        logic [31:0] a_rdata;
        logic [31:0] b_rdata;
    } sfpm_mem_s;

    sfpm_mem_s r;
    sfpm_mem_s next_r;

    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("data buffer depth must equal two to the address width");
    end

    // engine byte writes are applied after the bus write, so the engine's byte wins a same-word clash
    always_comb begin
        next_r = r;
        next_r.a_rdata = r.word[mem_port.a_addr];
        next_r.b_rdata = r.word[mem_port.b_addr];
        if (mem_port.a_wr) begin
            next_r.word[mem_port.a_addr] = mem_port.a_wdata;
        end
        for (int i = 0; i < 4; i++) begin
            if (mem_port.b_wbe[i]) begin
                next_r.word[mem_port.b_addr][i*8 +: 8] = mem_port.b_wdata[i*8 +: 8];
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign mem_port.a_rdata = r.a_rdata;
    assign mem_port.b_rdata = r.b_rdata;

endmodule : sfpm_data_mem

// *** rtl/sfpm_top.sv ***
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module sfpm_top #(
    parameter int DATA_WORDS = sfpm_pkg::DATA_WORDS
) (
    input wire logic ref_clk_in, // module clock, 50 MHz
    input wire logic reset_in, // async reset, active high
    input wire logic [sfpm_pkg::REG_AW-1:0] reg_addr_in, // register byte address
    input wire logic [sfpm_pkg::REG_DW-1:0] reg_wdata_in, // register write data
    input wire logic reg_write_in, // write strobe
    input wire logic reg_read_in, // read strobe
    output logic [sfpm_pkg::REG_DW-1:0] reg_rdata_out, // read data, cycle after strobe
    input wire logic tx_dma_req_clear_in, // dma withdraws transmit request
    input wire logic rx_dma_req_clear_in, // dma withdraws receive request
    output logic tx_dma_request_out, // transmit buffer may be refilled
    output logic rx_dma_request_out, // receive data waiting in buffer
    output logic irq_out, // level interrupt
    output logic sck_out, // serial clock, idle low
    output logic chip_select_low_out, // chip select, active low
    output logic lane0_data_out, // lane 0 data
    output logic lane0_output_enable_n_out, // lane 0 enable, low drives
    input wire logic lane0_data_in, // lane 0 pin level
    output logic lane1_data_out, // lane 1 data
    output logic lane1_output_enable_n_out, // lane 1 enable, low drives
    input wire logic lane1_data_in, // lane 1 pin level
    output logic lane2_data_out, // lane 2 data
    output logic lane2_output_enable_n_out, // lane 2 enable, low drives
    input wire logic lane2_data_in, // lane 2 pin level
    output logic lane3_data_out, // lane 3 data
    output logic lane3_output_enable_n_out, // lane 3 enable, low drives
    input wire logic lane3_data_in // lane 3 pin level
);
    import sfpm_pkg::*;

    localparam int WORD_AW = $clog2(DATA_WORDS);
    localparam int PTR_W = WORD_AW + 2;

    if (DATA_WORDS < 2 || DATA_WORDS > DATA_WINDOW_WORDS || DATA_WORDS != (1 << WORD_AW)) begin : g_bad_words
        $error("data buffer must be a power of two words that fits the data window");
    end

    typedef struct packed {
        logic done;
        logic use_dma;
        logic [LAST_W-1:0] last_phase;
        logic [DIV_W-1:0] div;
        logic [PHASES-1:0][PCFG_W-1:0] phase_cfg;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] enable;
        logic tx_req;
        logic rx_req;
        logic [REG_DW-1:0] rdata;
        logic rd_data_sel;
        logic [3:0] sync1;
        logic [3:0] sync2;
        sfpm_state_e state;
        logic [LAST_W-1:0] phase;
        logic [CNT_W-1:0] remain;
        logic [PTR_W-1:0] ptr;
        logic [DIV_W-1:0] div_cnt;
        logic [2:0] beat;
        logic [7:0] shreg;
        logic sck;
        logic cs_n;
        logic [3:0] lane_o;
        logic [3:0] lane_drv;
        logic had_write;
        logic had_read;
    } sfpm_top_s;

    sfpm_top_s r;
    sfpm_top_s next_r;

    sfpm_mem_if #(.AW(WORD_AW)) mem_bus ();

    sfpm_data_mem #(
        .DEPTH(DATA_WORDS),
        .AW(WORD_AW)
    ) u_data_mem (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .mem_port(mem_bus.mem)
    );

    // address decoding shared by reads and writes
    function automatic logic is_data(input logic [REG_AW-1:0] addr);
        return (addr & DATA_MASK) == DATA_BASE;
    endfunction : is_data

    function automatic logic is_phase(input logic [REG_AW-1:0] addr);
        return (addr & PHASE_MASK) == PHASE_BASE;
    endfunction : is_phase

    // lanes taking part in a phase of the given width
    function automatic logic [3:0] lane_mask(input logic [1:0] lanes);
        case (lanes)
            LANES_1: return 4'h1;
            LANES_2: return 4'h3;
            default: return 4'hf;
        endcase
    endfunction : lane_mask

    // msb-first bits put on the lanes for one serial clock
    function automatic logic [3:0] out_bits(input logic [1:0] lanes, input logic [7:0] sh);
        case (lanes)
            LANES_1: return {3'h0, sh[7]};
            LANES_2: return {2'h0, sh[7:6]};
            default: return sh[7:4];
        endcase
    endfunction : out_bits

    // one beat of shifting; a single-lane read listens on lane 1
    function automatic logic [7:0] shift_beat(input logic [1:0] lanes, input logic [7:0] sh,
                                              input logic [3:0] pins);
        case (lanes)
            LANES_1: return {sh[6:0], pins[1]};
            LANES_2: return {sh[5:0], pins[1:0]};
            default: return {sh[3:0], pins[3:0]};
        endcase
    endfunction : shift_beat

    function automatic logic [2:0] last_beat(input logic [1:0] lanes);
        case (lanes)
            LANES_1: return 3'h7;
            LANES_2: return 3'h3;
            default: return 3'h1;
        endcase
    endfunction : last_beat

    logic [PCFG_W-1:0] cur_cfg;
    logic [1:0] cur_lanes;
    logic cur_read;
    logic [CNT_W-1:0] cur_count;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] clear;
    logic start_go;
    logic phase_done;

    assign cur_cfg = r.phase_cfg[r.phase];
    assign cur_lanes = cur_cfg[LANES_LSB +: 2];
    assign cur_read = cur_cfg[DIR_BIT];
    assign cur_count = cur_cfg[CNT_LSB +: CNT_W];

    // bus side of the buffer is a plain word window, usable while a transfer runs
    assign mem_bus.a_wr = reg_write_in & is_data(reg_addr_in);
    assign mem_bus.a_addr = reg_addr_in[2 +: WORD_AW];
    assign mem_bus.a_wdata = reg_wdata_in;
    assign mem_bus.b_addr = r.ptr[PTR_W-1:2];
    assign mem_bus.b_wbe = (r.state == ST_STORE) ? (4'h1 << r.ptr[1:0]) : 4'h0;
    assign mem_bus.b_wdata = {4{r.shreg}};

    always_comb begin
        next_r = r;
        events = '0;
        clear = '0;
        start_go = 1'b0;
        phase_done = 1'b0;
        next_r.rdata = '0;
        next_r.rd_data_sel = 1'b0;
        // pins pass two flops before any logic looks at them
        next_r.sync1 = {lane3_data_in, lane2_data_in, lane1_data_in, lane0_data_in};
        next_r.sync2 = r.sync1;

        // register writes
        if (reg_write_in) begin
            if (reg_addr_in == CTRL_OFF) begin
                next_r.use_dma = reg_wdata_in[DMA_BIT];
                next_r.last_phase = reg_wdata_in[LAST_LSB +: LAST_W];
                next_r.div = reg_wdata_in[DIV_LSB +: DIV_W];
                if (reg_wdata_in[START_BIT]) begin
                    if (r.done && r.state == ST_IDLE) begin
                        start_go = 1'b1;
                    end else begin
                        events[EV_REJECT] = 1'b1;
                    end
                end
            end else if (reg_addr_in == CLEAR_OFF) begin
                clear = reg_wdata_in[EV_W-1:0];
            end else if (reg_addr_in == ENABLE_OFF) begin
                next_r.enable = reg_wdata_in[EV_W-1:0];
            end else if (is_phase(reg_addr_in)) begin
                next_r.phase_cfg[reg_addr_in[2 +: LAST_W]] = reg_wdata_in[PCFG_W-1:0];
            end
        end

        // register reads; unmapped and write-only offsets read zero
        if (reg_read_in) begin
            if (is_data(reg_addr_in)) begin
                next_r.rd_data_sel = 1'b1;
            end else if (reg_addr_in == CTRL_OFF) begin
                next_r.rdata[DONE_BIT] = r.done;
                next_r.rdata[DMA_BIT] = r.use_dma;
                next_r.rdata[LAST_LSB +: LAST_W] = r.last_phase;
                next_r.rdata[DIV_LSB +: DIV_W] = r.div;
            end else if (reg_addr_in == STATUS_OFF) begin
                next_r.rdata[EV_W-1:0] = r.status;
            end else if (reg_addr_in == ENABLE_OFF) begin
                next_r.rdata[EV_W-1:0] = r.enable;
            end else if (is_phase(reg_addr_in)) begin
                next_r.rdata[PCFG_W-1:0] = r.phase_cfg[reg_addr_in[2 +: LAST_W]];
            end
        end

        // sequencer and serial engine; no bus action is needed once started
        case (r.state)
            ST_IDLE: begin
                next_r.cs_n = 1'b1;
                next_r.sck = 1'b0;
                next_r.lane_o = IDLE_OUT;
                next_r.lane_drv = IDLE_DRIVE;
                if (start_go) begin
                    next_r.done = 1'b0;
                    next_r.cs_n = 1'b0;
                    next_r.phase = '0;
                    next_r.ptr = '0;
                    next_r.had_write = 1'b0;
                    next_r.had_read = 1'b0;
                    next_r.state = ST_PHASE;
                end
            end
            ST_PHASE: begin
                next_r.remain = cur_count;
                next_r.beat = '0;
                next_r.div_cnt = '0;
                next_r.shreg = '0;
                if (cur_read) begin
                    next_r.lane_drv = IDLE_DRIVE & ~lane_mask(cur_lanes);
                    next_r.lane_o = IDLE_OUT & ~lane_mask(cur_lanes);
                end else begin
                    next_r.lane_drv = IDLE_DRIVE | lane_mask(cur_lanes);
                end
                if (cur_count == '0) begin
                    phase_done = 1'b1;
                end else if (cur_read) begin
                    next_r.had_read = 1'b1;
                    next_r.state = ST_SHIFT;
                end else begin
                    next_r.had_write = 1'b1;
                    next_r.state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                next_r.state = ST_LOAD; // buffer read data is registered
            end
            ST_LOAD: begin
                next_r.shreg = mem_bus.b_rdata[{r.ptr[1:0], 3'h0} +: 8];
                next_r.lane_o = (IDLE_OUT & ~lane_mask(cur_lanes))
                    | (out_bits(cur_lanes, mem_bus.b_rdata[{r.ptr[1:0], 3'h0} +: 8]) & lane_mask(cur_lanes));
                next_r.beat = '0;
                next_r.div_cnt = '0;
                next_r.state = ST_SHIFT;
            end
            ST_SHIFT: begin
                // each half period within a byte lasts div+1 clocks, so sck never beats half the clock rate
                if (r.div_cnt == r.div) begin
                    next_r.div_cnt = '0;
                    next_r.sck = ~r.sck;
                    if (!r.sck) begin
                        if (cur_read) begin
                            next_r.shreg = shift_beat(cur_lanes, r.shreg, r.sync2);
                        end
                    end else begin
                        next_r.beat = r.beat + 3'h1;
                        if (!cur_read) begin
                            next_r.shreg = shift_beat(cur_lanes, r.shreg, 4'h0);
                            next_r.lane_o = (IDLE_OUT & ~lane_mask(cur_lanes))
                                | (out_bits(cur_lanes, shift_beat(cur_lanes, r.shreg, 4'h0))
                                   & lane_mask(cur_lanes));
                        end
                        if (r.beat == last_beat(cur_lanes)) begin
                            if (cur_read) begin
                                next_r.state = ST_STORE;
                            end else begin
                                next_r.ptr = r.ptr + PTR_W'(1);
                                next_r.remain = r.remain - CNT_W'(1);
                                if (r.remain == CNT_W'(1)) begin
                                    phase_done = 1'b1;
                                end else begin
                                    next_r.state = ST_FETCH;
                                end
                            end
                        end
                    end
                end else begin
                    next_r.div_cnt = r.div_cnt + DIV_W'(1);
                end
            end
            ST_STORE: begin
                // the buffer takes the received byte this cycle
                next_r.ptr = r.ptr + PTR_W'(1);
                next_r.remain = r.remain - CNT_W'(1);
                next_r.beat = '0;
                next_r.shreg = '0;
                if (r.remain == CNT_W'(1)) begin
                    phase_done = 1'b1;
                end else begin
                    next_r.state = ST_SHIFT;
                end
            end
            ST_END: begin
                next_r.cs_n = 1'b1;
                next_r.done = 1'b1;
                events[EV_DONE] = 1'b1;
                next_r.lane_o = IDLE_OUT;
                next_r.lane_drv = IDLE_DRIVE;
                next_r.state = ST_IDLE;
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase

        // strictly ascending, stopping after the last enabled phase
        if (phase_done) begin
            if (r.phase == r.last_phase) begin
                next_r.state = ST_END;
            end else begin
                next_r.phase = r.phase + LAST_W'(1);
                next_r.state = ST_PHASE;
            end
        end

        // sticky events: a new event beats a clear in the same cycle
        next_r.status = (r.status & ~clear) | events;
        // dma requests follow the same rule against the dma clear pulses
        next_r.tx_req = (r.tx_req & ~tx_dma_req_clear_in)
            | (events[EV_DONE] & r.use_dma & r.had_write);
        next_r.rx_req = (r.rx_req & ~rx_dma_req_clear_in)
            | (events[EV_DONE] & r.use_dma & r.had_read);
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            r <= '0;
            r.done <= 1'b1;
            r.div <= DIV_RESET;
            r.cs_n <= 1'b1;
            r.lane_o <= IDLE_OUT;
            r.lane_drv <= IDLE_DRIVE;
            r.state <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // outputs from registers only; read data may come from the buffer's read register, irq gated by enable
    assign reg_rdata_out = r.rd_data_sel ? mem_bus.a_rdata : r.rdata;
    assign irq_out = |(r.status & r.enable);
    assign tx_dma_request_out = r.tx_req;
    assign rx_dma_request_out = r.rx_req;
    assign sck_out = r.sck;
    assign chip_select_low_out = r.cs_n;
    assign lane0_data_out = r.lane_o[0];
    assign lane1_data_out = r.lane_o[1];
    assign lane2_data_out = r.lane_o[2];
    assign lane3_data_out = r.lane_o[3];
    assign lane0_output_enable_n_out = ~r.lane_drv[0];
    assign lane1_output_enable_n_out = ~r.lane_drv[1];
    assign lane2_output_enable_n_out = ~r.lane_drv[2];
    assign lane3_output_enable_n_out = ~r.lane_drv[3];

endmodule : sfpm_top

// *** verif/sfpm_assertions.sv ***
`timescale 1ns/1ps
module sfpm_checker (
    input wire logic ref_clk_in, // module clock
    input wire logic reset_in, // async reset
    input wire logic [sfpm_pkg::REG_AW-1:0] reg_addr_in, // address
    input wire logic [sfpm_pkg::REG_DW-1:0] reg_wdata_in, // write data
    input wire logic reg_write_in, // write strobe
    input wire logic reg_read_in, // read strobe
    input wire logic [sfpm_pkg::REG_DW-1:0] reg_rdata_out, // read data
    input wire logic tx_dma_req_clear_in, // tx clear
    input wire logic rx_dma_req_clear_in, // rx clear
    input wire logic tx_dma_request_out, // tx request
    input wire logic rx_dma_request_out, // rx request
    input wire logic irq_out, // interrupt
    input wire logic sck_out, // serial clock
    input wire logic chip_select_low_out, // chip select
    input wire logic lane0_output_enable_n_out, // lane 0 enable
    input wire logic lane1_output_enable_n_out, // lane 1 enable
    input wire logic lane2_output_enable_n_out, // lane 2 enable
    input wire logic lane3_output_enable_n_out // lane 3 enable
);
    import sfpm_pkg::*;
    logic [7:0] div_q;
    logic [8:0] hi_cnt;
    logic cs_q;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // shadow of the divider; the control write made mid-transfer repeats the divider, so no mid-period change
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_q <= DIV_RESET;
            hi_cnt <= 9'h0;
            cs_q <= 1'b1;
        end else begin
            if (reg_write_in && reg_addr_in == CTRL_OFF) begin
                div_q <= reg_wdata_in[DIV_LSB+:DIV_W];
            end
            hi_cnt <= sck_out ? hi_cnt + 9'h1 : 9'h0;
            cs_q <= chip_select_low_out;
        end
    end
    sequence start_write;
        reg_write_in && reg_addr_in == CTRL_OFF && reg_wdata_in[START_BIT];
    endsequence
    a_idle_sck_low: assert property (chip_select_low_out |-> !sck_out) else $error("sck high while idle");
    a_sck_high_time: assert property ($fell(sck_out) |-> hi_cnt == {1'b0, div_q} + 9'h1)
        else $error("sck high time wrong");
    a_start_frames: assert property ($fell(chip_select_low_out) |->
        $past(reg_write_in && reg_addr_in == CTRL_OFF && reg_wdata_in[START_BIT])) else $error("frame without start");
    a_read_data_once: assert property (!$past(reg_read_in) |-> reg_rdata_out == '0)
        else $error("read data outside its cycle");
    a_tx_clear_works: assert property (tx_dma_req_clear_in && chip_select_low_out |=> !tx_dma_request_out)
        else $error("tx request not cleared");
    a_rx_clear_works: assert property (rx_dma_req_clear_in && chip_select_low_out |=> !rx_dma_request_out)
        else $error("rx request not cleared");
    a_dma_at_end: assert property ($rose(tx_dma_request_out) |-> chip_select_low_out &&
        (!cs_q || !$past(cs_q))) else $error("tx request not at frame end");
    a_lane_pairing: assert property (!lane1_output_enable_n_out |-> !lane0_output_enable_n_out)
        else $error("lane 1 driven without lane 0");
    a_idle_lanes: assert property (chip_select_low_out && cs_q |-> ~IDLE_DRIVE ==
        {lane3_output_enable_n_out, lane2_output_enable_n_out, lane1_output_enable_n_out, lane0_output_enable_n_out})
        else $error("idle lane enables wrong");
    a_irq_drop_write: assert property ($fell(irq_out) |-> $past(reg_write_in)) else $error("irq fell alone");
    c_start_frame: cover property (start_write ##[1:3] !chip_select_low_out);
endmodule : sfpm_checker
bind sfpm_top sfpm_checker chk_u (.*);

// *** verif/sfpm_flash_model.sv ***
`timescale 1ns/1ps
module sfpm_flash_model #(
    parameter logic [7:0] RESP = 8'h3c // byte returned in read phases
) (
    input wire logic sck_in, // serial clock
    input wire logic cs_n_in, // chip select, active low
    input wire logic lane0_in, // lane 0 pin level
    input wire logic lane0_oe_n_in, // controller lane 0 enable
    input wire logic lane1_oe_n_in, // controller lane 1 enable
    output logic drive_out, // model drives lane 1
    output logic bit_out, // lane 1 value
    output logic [7:0] cap_out, // bits taken from lane 0
    output logic [7:0] rises_out // rising sck edges seen
);
    logic [2:0] idx = 3'h0;
    // only drive when selected and both lanes are released; otherwise the controller drives lane 1 or the pull-up holds it high
    assign drive_out = !cs_n_in && lane0_oe_n_in && lane1_oe_n_in;
    assign bit_out = RESP[~idx];
    initial cap_out = 8'h00;
    initial rises_out = 8'h00;
    // mode 0: take lane 0 on the rising edge while the controller drives it
    always @(posedge sck_in) begin
        rises_out <= rises_out + 8'h1;
        if (!cs_n_in && !lane0_oe_n_in) cap_out <= {cap_out[6:0], lane0_in};
    end
    // next output bit after each falling edge of a read phase
    always @(negedge sck_in) begin
        if (drive_out) idx <= idx + 3'h1;
    end
endmodule : sfpm_flash_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    import sfpm_pkg::*;
    logic ref_clk_in, reset_in, wr, rd_s, txc, rxc, txr, rxr, irq, sck, cs_n, p_drv, p_bit;
    logic [7:0] addr, cap, rises;
    logic [31:0] wd, rdat, d;
    logic [3:0] lo, loe_n, pin;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    sfpm_top dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wd),
        .reg_write_in(wr), .reg_read_in(rd_s), .reg_rdata_out(rdat), .tx_dma_req_clear_in(txc),
        .rx_dma_req_clear_in(rxc), .tx_dma_request_out(txr), .rx_dma_request_out(rxr), .irq_out(irq),
        .sck_out(sck), .chip_select_low_out(cs_n), .lane0_data_out(lo[0]), .lane0_output_enable_n_out(loe_n[0]),
        .lane0_data_in(pin[0]), .lane1_data_out(lo[1]), .lane1_output_enable_n_out(loe_n[1]),
        .lane1_data_in(pin[1]), .lane2_data_out(lo[2]), .lane2_output_enable_n_out(loe_n[2]),
        .lane2_data_in(pin[2]), .lane3_data_out(lo[3]), .lane3_output_enable_n_out(loe_n[3]),
        .lane3_data_in(pin[3]));
    sfpm_flash_model flash_u (.sck_in(sck), .cs_n_in(cs_n), .lane0_in(pin[0]), .lane0_oe_n_in(loe_n[0]),
        .lane1_oe_n_in(loe_n[1]), .drive_out(p_drv), .bit_out(p_bit), .cap_out(cap), .rises_out(rises));
    // pin levels: controller, then flash, then the pull-up
    assign pin[0] = loe_n[0] ? 1'b1 : lo[0];
    assign pin[1] = !loe_n[1] ? lo[1] : (p_drv ? p_bit : 1'b1);
    assign pin[2] = loe_n[2] ? 1'b1 : lo[2];
    assign pin[3] = loe_n[3] ? 1'b1 : lo[3];
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_in);
        addr <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    // data stands only in the cycle after the strobe, so look just past the taking edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_in);
        rd_s <= 1'b0;
        #1 v = rdat;
    endtask : rd_reg
    task automatic wait_done();
        for (int i = 0; i < 400; i++) begin
            rd_reg(STATUS_OFF, d);
            if (d[EV_DONE] === 1'b1) break;
        end
    endtask : wait_done
    task automatic pulse_clear();
        @(posedge ref_clk_in);
        txc <= 1'b1;
        rxc <= 1'b1;
        @(posedge ref_clk_in);
        txc <= 1'b0;
        rxc <= 1'b0;
    endtask : pulse_clear
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // a hang ends the run; the whole sequence needs a few hundred cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        {wr, rd_s, txc, rxc, addr, wd} = '0;
        reset_in = 1'b1;
        repeat (10) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd_reg(CTRL_OFF, d); `CHK(d, 32'h0000_0102)
        rd_reg(STATUS_OFF, d); `CHK(d, 32'h0)
        rd_reg(8'h10, d); `CHK(d, 32'h0)
        `CHK({sck, cs_n, irq}, 3'h2)
        wr_reg(DATA_BASE, 32'h0000_00a5);
        wr_reg(PHASE_BASE, 32'h0010);
        wr_reg(PHASE_BASE + 8'h4, 32'h0011);
        wr_reg(PHASE_BASE + 8'h8, 32'h0014);
        wr_reg(ENABLE_OFF, 32'h3);
        // write one byte, read one byte, third phase beyond the last index
        wr_reg(CTRL_OFF, 32'h0000_0215);
        wait_done();
        `CHK(d, 32'h1)
        `CHK(irq, 1'b1)
        `CHK(cap, 8'ha5)
        `CHK(rises, 8'h10)
        `CHK({txr, rxr}, 2'h3)
        rd_reg(DATA_BASE, d); `CHK(d, 32'h0000_3ca5)
        rd_reg(CTRL_OFF, d); `CHK(d, 32'h0000_0216)
        pulse_clear();
        @(negedge ref_clk_in); `CHK({txr, rxr}, 2'h0)
        wr_reg(CLEAR_OFF, 32'h1);
        rd_reg(STATUS_OFF, d); `CHK(d, 32'h0)
        `CHK(irq, 1'b0)
        // second start while the first one runs must be refused
        wr_reg(CTRL_OFF, 32'h0000_0221);
        wr_reg(CTRL_OFF, 32'h0000_0221);
        rd_reg(STATUS_OFF, d); `CHK(d[EV_REJECT], 1'b1)
        `CHK(irq, 1'b1)
        wait_done();
        `CHK(d, 32'h3)
        `CHK({txr, rxr}, 2'h0)
        `CHK({rises, cap}, 16'h2294)
        give_verdict();
    end
endmodule : testbench
